// *** core/fifo_defines.vh ***
`ifndef FIFO_DEFINES_VH
`define FIFO_DEFINES_VH

// register indices on the plain software port
`define REG_STATUS 2'h0
`define REG_CTRL 2'h1
`define REG_AE_OFF 2'h2
`define REG_AF_OFF 2'h3

// status register fields
`define ST_EMPTY 0
`define ST_FULL 1
`define ST_HALF 2
`define ST_AE 3
`define ST_AF 4
`define ST_WTOK 5
`define ST_RTOK 6
`define ST_COUNT_LSB 16

// control register fields
`define CTRL_CASCADE 0

// offset register reset value
`define OFF_DEFAULT 18'h0007F

// positions of the control pins in the synchroniser vector
`define PIN_WCLK 0
`define PIN_WEN_N 1
`define PIN_RCLK 2
`define PIN_REN_N 3
`define PIN_LD_N 4
`define PIN_RT_N 5
`define PIN_FL 6
`define PIN_WXI 7
`define PIN_RXI 8
`define PIN_RS_N 9
`define PIN_FLAG_SYNC_SELECT 10
`define PIN_OE_N 11
`define PIN_COUNT 12

`endif

// *** core/fifo_mem.v ***
`timescale 1ns/1ps
`default_nettype none

// simple dual-port store; read data comes out of a register
module fifo_mem #(
    parameter DW = 18,
    parameter AW = 14
) (
    input wire clk_in,
    input wire ce_in,
    input wire wr_en_in,
    input wire [AW-1:0] wr_addr_in,
    input wire [DW-1:0] wr_data_in,
    input wire rd_en_in,
    input wire [AW-1:0] rd_addr_in,
    output reg [DW-1:0] rd_data_out
);
    reg [DW-1:0] mem_r [0:(1<<AW)-1];

    // no reset on the array or read register so it maps onto block ram
    always @(posedge clk_in) begin
        if (ce_in) begin
            if (wr_en_in) begin
                mem_r[wr_addr_in] <= wr_data_in;
            end
            if (rd_en_in) begin
                rd_data_out <= mem_r[rd_addr_in];
            end
        end
    end
endmodule // fifo_mem

`default_nettype wire

// *** core/deep_sync_fifo.v ***
// What this block does
// - write clock edge stores word unless full
// - input and output ports 18 bits wide
// - read clock edge presents next word unless empty
// - load low routes data to offset register
// - offset register reads clocked by read clock
// - shared pin: half full or cascade write
// - empty flag low when empty, read side
// - full flag low when full, write side
// - almost empty flag within programmed offset
// - almost full flag within programmed offset
// - select pin picks async or clocked almost flags
// - retransmit strobe restarts reading from start, cascade mode off only
// - cascade read output feeds next device
// - fifo reset empties fifo and flags
// - output enable low drives read bus
`timescale 1ns/1ps
`default_nettype none
`include "fifo_defines.vh"

module deep_sync_fifo #(
    parameter DW = 18,
    parameter AW = 14
) (
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire write_clock_in,
    input wire write_enable_n_in,
    input wire [DW-1:0] write_bus_in,
    input wire read_clock_in,
    input wire read_enable_n_in,
    input wire offset_load_n_in,
    input wire retransmit_strobe_in,
    input wire first_load_select_in,
    input wire cascade_write_in,
    input wire cascade_read_in,
    input wire fifo_reset_n_in,
    input wire flag_sync_select_in,
    input wire output_enable_n_in,
    output wire [DW-1:0] read_bus_out,
    output wire read_bus_oe_out,
    output wire empty_flag_n_out,
    output wire full_flag_n_out,
    output wire almost_empty_flag_n_out,
    output wire almost_full_flag_n_out,
    output wire half_full_n_or_cascade_write_out,
    output wire cascade_read_out,
    input wire [1:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out
);
    localparam NP = `PIN_COUNT;
    localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
    localparam [AW:0] HALF = {2'b01, {(AW-1){1'b0}}};
    localparam [AW:0] CNT_ZERO = {(AW+1){1'b0}};
    localparam [AW-1:0] PTR_ONE = {{(AW-1){1'b0}}, 1'b1};

    // three-stage synchronisers on every pin, data included
    reg [NP-1:0] pin_s1_r;
    reg [NP-1:0] pin_s2_r;
    reg [NP-1:0] pin_s3_r;
    reg [NP-1:0] pin_lev_r;
    reg [DW-1:0] dat_s1_r;
    reg [DW-1:0] dat_s2_r;
    reg [DW-1:0] dat_s3_r;
    wire [NP-1:0] pin_rise;
    wire [NP-1:0] pin_fall;
    wire [NP-1:0] pin_agree;
    wire [NP-1:0] pin_lev_nxt;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_s1_r <= {NP{1'b0}};
            pin_s2_r <= {NP{1'b0}};
            pin_s3_r <= {NP{1'b0}};
            dat_s1_r <= {DW{1'b0}};
            dat_s2_r <= {DW{1'b0}};
            dat_s3_r <= {DW{1'b0}};
        end else if (ce_in) begin
            pin_s1_r <= {output_enable_n_in, flag_sync_select_in, fifo_reset_n_in,
                         cascade_read_in, cascade_write_in, first_load_select_in,
                         retransmit_strobe_in, offset_load_n_in, read_enable_n_in,
                         read_clock_in, write_enable_n_in, write_clock_in};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            dat_s1_r <= write_bus_in;
            dat_s2_r <= dat_s1_r;
            dat_s3_r <= dat_s2_r;
        end
    end

    // a change counts only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi = gi + 1) begin : g_pin
            assign pin_agree[gi] = (pin_s2_r[gi] == pin_s3_r[gi]);
            assign pin_rise[gi] = pin_agree[gi] & pin_s3_r[gi] & ~pin_lev_r[gi];
            assign pin_fall[gi] = pin_agree[gi] & ~pin_s3_r[gi] & pin_lev_r[gi];
            assign pin_lev_nxt[gi] = pin_agree[gi] ? pin_s3_r[gi] : pin_lev_r[gi];
        end
    endgenerate

    // one process for the whole vector keeps a single driver on the level register
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_lev_r <= {NP{1'b0}};
        end else if (ce_in) begin
            pin_lev_r <= pin_lev_nxt;
        end
    end

    wire w_ev = pin_rise[`PIN_WCLK];
    wire r_ev = pin_rise[`PIN_RCLK];
    wire load_n = pin_lev_r[`PIN_LD_N];
    wire rs_n = pin_lev_r[`PIN_RS_N];
    wire fl_lev = pin_lev_r[`PIN_FL];

    // fifo state
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    reg empty_r;
    reg full_r;
    reg ae_r;
    reg af_r;
    reg [DW-1:0] ae_off_r;
    reg [DW-1:0] af_off_r;
    reg wseq_r;
    reg rseq_r;
    reg [DW-1:0] out_r;
    reg pend_r;
    reg wtok_r;
    reg rtok_r;
    reg wxo_r;
    reg rxo_r;
    reg cascade_r;
    wire [DW-1:0] mem_rd_data;

    wire wtok = ~cascade_r | wtok_r;
    wire rtok = ~cascade_r | rtok_r;
    wire wr_do = w_ev & load_n & ~pin_lev_r[`PIN_WEN_N] & ~full_r & wtok;
    wire rd_do = r_ev & load_n & ~pin_lev_r[`PIN_REN_N] & ~empty_r & rtok;
    wire rt_do = pin_fall[`PIN_RT_N] & ~cascade_r;

    reg [AW:0] count_nxt;
    always @* begin
        count_nxt = count_r;
        if (wr_do && !rd_do) begin
            count_nxt = count_r + {{AW{1'b0}}, 1'b1};
        end else if (rd_do && !wr_do) begin
            count_nxt = count_r - {{AW{1'b0}}, 1'b1};
        end
    end

    function is_almost_empty;
        input [AW:0] cnt;
        input [DW-1:0] off;
        begin
            is_almost_empty = ({1'b0, cnt} <= {2'b00, off[AW-1:0]});
        end
    endfunction

    function is_almost_full;
        input [AW:0] cnt;
        input [DW-1:0] off;
        begin
            is_almost_full = (({1'b0, cnt} + {2'b00, off[AW-1:0]}) >= {1'b0, DEPTH});
        end
    endfunction

    fifo_mem #(
        .DW(DW),
        .AW(AW)
    ) u_mem (
        .clk_in(clk_in),
        .ce_in(ce_in),
        .wr_en_in(wr_do),
        .wr_addr_in(wr_ptr_r),
        .wr_data_in(dat_s3_r),
        .rd_en_in(rd_do),
        .rd_addr_in(rd_ptr_r),
        .rd_data_out(mem_rd_data)
    );

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= CNT_ZERO;
            empty_r <= 1'b1;
            full_r <= 1'b0;
            ae_r <= 1'b1;
            af_r <= 1'b0;
            ae_off_r <= `OFF_DEFAULT;
            af_off_r <= `OFF_DEFAULT;
            wseq_r <= 1'b0;
            rseq_r <= 1'b0;
            out_r <= {DW{1'b0}};
            pend_r <= 1'b0;
            wtok_r <= 1'b0;
            rtok_r <= 1'b0;
            wxo_r <= 1'b0;
            rxo_r <= 1'b0;
        end else if (ce_in) begin
            wxo_r <= 1'b0;
            rxo_r <= 1'b0;
            pend_r <= rd_do;
            if (pend_r) begin
                out_r <= mem_rd_data;
            end
            if (!rs_n) begin
                // pin reset clears pointers and flags; tokens go to the first device
                wr_ptr_r <= {AW{1'b0}};
                rd_ptr_r <= {AW{1'b0}};
                count_r <= CNT_ZERO;
                empty_r <= 1'b1;
                full_r <= 1'b0;
                ae_r <= 1'b1;
                af_r <= 1'b0;
                ae_off_r <= `OFF_DEFAULT;
                af_off_r <= `OFF_DEFAULT;
                wseq_r <= 1'b0;
                rseq_r <= 1'b0;
                pend_r <= 1'b0;
                wtok_r <= ~fl_lev;
                rtok_r <= ~fl_lev;
            end else begin
                if (w_ev && !load_n) begin
                    if (wseq_r) begin
                        af_off_r <= dat_s3_r;
                    end else begin
                        ae_off_r <= dat_s3_r;
                    end
                    wseq_r <= ~wseq_r;
                end
                if (r_ev && !load_n) begin
                    out_r <= rseq_r ? af_off_r : ae_off_r;
                    rseq_r <= ~rseq_r;
                end
                if (wr_do) begin
                    wr_ptr_r <= wr_ptr_r + PTR_ONE;
                end
                if (rt_do) begin
                    // restart from location zero; only exact while no wrap has occurred
                    rd_ptr_r <= {AW{1'b0}};
                    count_r <= (full_r || (wr_ptr_r == {AW{1'b0}} && count_r != CNT_ZERO)) ?
                               DEPTH : {1'b0, wr_ptr_r};
                end else begin
                    if (rd_do) begin
                        rd_ptr_r <= rd_ptr_r + PTR_ONE;
                    end
                    count_r <= count_nxt;
                end
                if (r_ev) begin
                    empty_r <= (count_nxt == CNT_ZERO);
                    ae_r <= is_almost_empty(count_nxt, ae_off_r);
                end
                if (w_ev) begin
                    full_r <= (count_nxt == DEPTH);
                    af_r <= is_almost_full(count_nxt, af_off_r);
                end
                // write token moves on when this device fills
                if (cascade_r && pin_rise[`PIN_WXI]) begin
                    wtok_r <= 1'b1;
                end else if (cascade_r && wr_do && count_nxt == DEPTH) begin
                    wtok_r <= 1'b0;
                    wxo_r <= 1'b1;
                end
                // read token moves on when drained and no longer written
                if (cascade_r && pin_rise[`PIN_RXI]) begin
                    rtok_r <= 1'b1;
                end else if (cascade_r && rd_do && count_nxt == CNT_ZERO && !wtok_r) begin
                    rtok_r <= 1'b0;
                    rxo_r <= 1'b1;
                end
            end
        end
    end

    wire ae_comb = is_almost_empty(count_r, ae_off_r);
    wire af_comb = is_almost_full(count_r, af_off_r);
    wire async_sel = pin_lev_r[`PIN_FLAG_SYNC_SELECT];
    wire half = (count_r > HALF);

    assign read_bus_out = out_r;
    assign read_bus_oe_out = ~pin_lev_r[`PIN_OE_N];
    assign empty_flag_n_out = ~empty_r;
    assign full_flag_n_out = ~full_r;
    assign almost_empty_flag_n_out = ~(async_sel ? ae_comb : ae_r);
    assign almost_full_flag_n_out = ~(async_sel ? af_comb : af_r);
    assign half_full_n_or_cascade_write_out = cascade_r ? wxo_r : ~half;
    assign cascade_read_out = rxo_r;

    // software port: control write, status and offsets readback
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cascade_r <= 1'b0;
            reg_rdata_out <= 32'h00000000;
        end else if (ce_in) begin
            if (reg_wr_in && reg_addr_in == `REG_CTRL) begin
                cascade_r <= reg_wdata_in[`CTRL_CASCADE];
            end
            reg_rdata_out <= 32'h00000000;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `REG_STATUS: begin
                        reg_rdata_out[`ST_EMPTY] <= empty_r;
                        reg_rdata_out[`ST_FULL] <= full_r;
                        reg_rdata_out[`ST_HALF] <= half;
                        reg_rdata_out[`ST_AE] <= ae_comb;
                        reg_rdata_out[`ST_AF] <= af_comb;
                        reg_rdata_out[`ST_WTOK] <= wtok;
                        reg_rdata_out[`ST_RTOK] <= rtok;
                        reg_rdata_out[`ST_COUNT_LSB+AW:`ST_COUNT_LSB] <= count_r;
                    end
                    `REG_CTRL: begin
                        reg_rdata_out[`CTRL_CASCADE] <= cascade_r;
                    end
                    `REG_AE_OFF: begin
                        reg_rdata_out[DW-1:0] <= ae_off_r;
                    end
                    `REG_AF_OFF: begin
                        reg_rdata_out[DW-1:0] <= af_off_r;
                    end
                    default: begin
                        reg_rdata_out <= 32'h00000000;
                    end
                endcase
            end
        end
    end
endmodule // deep_sync_fifo

`default_nettype wire

// *** verification/deep_sync_fifo_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module deep_sync_fifo_checker #(
    parameter int DW = 18,
    parameter int AW = 14
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic write_clock_in,
    input wire logic read_clock_in,
    input wire logic fifo_reset_n_in,
    input wire logic flag_sync_select_in,
    input wire logic output_enable_n_in,
    input wire logic reg_rd_in,
    input wire logic [DW-1:0] read_bus_out,
    input wire logic read_bus_oe_out,
    input wire logic empty_flag_n_out,
    input wire logic full_flag_n_out,
    input wire logic almost_empty_flag_n_out,
    input wire logic almost_full_flag_n_out,
    input wire logic [31:0] reg_rdata_out
);
    // cycles since a pin was last active; pins pass three sync flops first
    logic [3:0] wc_r, rc_r, fr_r, sel_r;
    function automatic logic [3:0] age(input logic hit, input logic [3:0] a);
        return hit ? 4'h0 : a + {3'h0, a != 4'hF};
    endfunction
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wc_r <= 4'h0;
            rc_r <= 4'h0;
            fr_r <= 4'h0;
            sel_r <= 4'h0;
        end else begin
            wc_r <= age(write_clock_in, wc_r);
            rc_r <= age(read_clock_in, rc_r);
            fr_r <= age(!fifo_reset_n_in, fr_r);
            sel_r <= age(flag_sync_select_in, sel_r);
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_oe_off:
        assert property ((output_enable_n_in && ce_in) [*5] |-> !read_bus_oe_out)
        else $error("bus driven while disabled");
    a_oe_on:
        assert property ((!output_enable_n_in && ce_in) [*5] |-> read_bus_oe_out)
        else $error("bus not driven while enabled");
    a_empty_side:
        assert property ($changed(empty_flag_n_out) |-> rc_r < 4'h8 || fr_r < 4'h8)
        else $error("empty flag moved without read clock");
    a_full_side:
        assert property ($changed(full_flag_n_out) |-> wc_r < 4'h8 || fr_r < 4'h8)
        else $error("full flag moved without write clock");
    a_rbus_cause:
        assert property ($changed(read_bus_out) |-> rc_r < 4'hA || fr_r < 4'h8)
        else $error("read bus moved without read clock");
    a_ae_clocked:
        assert property ($changed(almost_empty_flag_n_out) && sel_r > 4'h6
            |-> rc_r < 4'h8 || fr_r < 4'h8)
        else $error("registered almost empty moved without read clock");
    a_af_clocked:
        assert property ($changed(almost_full_flag_n_out) && sel_r > 4'h6
            |-> wc_r < 4'h8 || fr_r < 4'h8)
        else $error("registered almost full moved without write clock");
    a_reset_clears:
        assert property ((!fifo_reset_n_in && ce_in) [*6] |-> !empty_flag_n_out
            && full_flag_n_out && !almost_empty_flag_n_out && almost_full_flag_n_out)
        else $error("fifo reset did not clear flags");
    a_rdata_idle:
        assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data outside its cycle");
endmodule // deep_sync_fifo_checker
`default_nettype wire

// *** verification/fifo_far_side.sv ***
`timescale 1ns/1ps
`default_nettype none
// producer and consumer logic; pin clocks stay low between frames
module fifo_far_side #(
    parameter int DW = 18
) (
    input wire logic clk_in,
    output logic write_clock_out,
    output logic write_enable_n_out,
    output logic [DW-1:0] write_bus_out,
    output logic read_clock_out,
    output logic read_enable_n_out,
    output logic offset_load_n_out
);
    initial begin
        write_clock_out = 1'b0;
        read_clock_out = 1'b0;
        write_enable_n_out = 1'b1;
        read_enable_n_out = 1'b1;
        offset_load_n_out = 1'b1;
        write_bus_out = '0;
    end
    task automatic frame(input logic rd, input logic ld, input logic [DW-1:0] d);
        @(posedge clk_in);
        offset_load_n_out <= !ld;
        read_enable_n_out <= !rd;
        write_enable_n_out <= rd;
        write_bus_out <= d;
        // setup spans the design's three-flop sampling of every pin
        repeat (4) @(posedge clk_in);
        read_clock_out <= rd;
        write_clock_out <= !rd;
        repeat (5) @(posedge clk_in);
        read_clock_out <= 1'b0;
        write_clock_out <= 1'b0;
        repeat (5) @(posedge clk_in);
        // released data lines show a fresh pattern, not the last word
        write_bus_out <= ~write_bus_out;
        write_enable_n_out <= 1'b1;
        read_enable_n_out <= 1'b1;
        offset_load_n_out <= 1'b1;
    endtask
endmodule // fifo_far_side
`default_nettype wire

// *** verification/deep_sync_fifo_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module deep_sync_fifo_tb;
    localparam int AW = 4;
    localparam int DEPTH = 1 << AW;
    logic clk_in, rst_in, fifo_reset_n_in, retransmit_strobe_in, flag_sync_select_in;
    logic output_enable_n_in, reg_wr_in, reg_rd_in, read_bus_oe_out, cascade_read_out;
    logic empty_flag_n_out, full_flag_n_out, almost_empty_flag_n_out, almost_full_flag_n_out;
    logic half_full_n_or_cascade_write_out, wclk, wen_n, rclk, ren_n, ld_n;
    logic ce_in, fl, cwi, cri;
    int wxo_n, rxo_n;
    bit casc;
    logic [1:0] reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, seed;
    logic [17:0] read_bus_out, wbus;
    int err_total, checks, q[$], hist[$], oae, oaf, ldw, ldr, last;
    bit e, f, aer, afr;
    fifo_far_side #(.DW(18)) far (.clk_in(clk_in), .write_clock_out(wclk),
        .write_enable_n_out(wen_n), .write_bus_out(wbus), .read_clock_out(rclk),
        .read_enable_n_out(ren_n), .offset_load_n_out(ld_n));
    deep_sync_fifo #(.DW(18), .AW(AW)) dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .write_clock_in(wclk), .write_enable_n_in(wen_n), .write_bus_in(wbus),
        .read_clock_in(rclk), .read_enable_n_in(ren_n), .offset_load_n_in(ld_n),
        .retransmit_strobe_in(retransmit_strobe_in),
        .first_load_select_in(fl),
        .cascade_write_in(cwi), .cascade_read_in(cri),
        .fifo_reset_n_in(fifo_reset_n_in), .flag_sync_select_in(flag_sync_select_in),
        .output_enable_n_in(output_enable_n_in), .read_bus_out(read_bus_out),
        .read_bus_oe_out(read_bus_oe_out), .empty_flag_n_out(empty_flag_n_out),
        .full_flag_n_out(full_flag_n_out), .almost_empty_flag_n_out(almost_empty_flag_n_out),
        .almost_full_flag_n_out(almost_full_flag_n_out),
        .half_full_n_or_cascade_write_out(half_full_n_or_cascade_write_out),
        .cascade_read_out(cascade_read_out), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // cascade pulses last one cycle, so they are counted as they pass
    always @(posedge clk_in) begin
        if (casc && half_full_n_or_cascade_write_out) wxo_n <= wxo_n + 1;
        if (cascade_read_out) rxo_n <= rxo_n + 1;
    end
    function automatic logic [17:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[17:0];
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic flags();
        int n;
        n = q.size();
        cmp(empty_flag_n_out, !e);
        cmp(full_flag_n_out, !f);
        cmp(half_full_n_or_cascade_write_out, casc ? 1'b0 : n <= DEPTH / 2);
        cmp(almost_empty_flag_n_out, flag_sync_select_in ? n > oae : !aer);
        cmp(almost_full_flag_n_out, flag_sync_select_in ? n + oaf < DEPTH : !afr);
    endtask
    task automatic wr(input logic [17:0] d, input bit ld);
        far.frame(1'b0, ld, d);
        if (ld) begin
            if (ldw == 0) oae = d;
            else oaf = d;
            ldw ^= 1;
        end else begin
            if (!f) begin
                q.push_back(d);
                hist.push_back(d);
            end
            f = q.size() == DEPTH;
            afr = q.size() + oaf >= DEPTH;
        end
        flags();
    endtask
    task automatic rd(input bit ld);
        far.frame(1'b1, ld, '0);
        if (ld) begin
            last = ldr ? oaf : oae;
            ldr ^= 1;
            cmp(read_bus_out, last);
        end else begin
            if (!e) last = q.pop_front();
            cmp(read_bus_out, last);
            e = q.size() == 0;
            aer = q.size() <= oae;
        end
        flags();
    endtask
    task automatic fifo_clear();
        fifo_reset_n_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        fifo_reset_n_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        q.delete();
        hist.delete();
        e = 1;
        f = 0;
        aer = 1;
        afr = 0;
        oae = 'h7F % DEPTH;
        oaf = 'h7F % DEPTH;
        ldw = 0;
        ldr = 0;
        flags();
    endtask
    task automatic reg_io(input logic [1:0] a, input logic [31:0] d, input bit w);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= w;
        reg_rd_in <= !w;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        #1;
    endtask
    task automatic finish_test();
        if (err_total == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {rst_in, fifo_reset_n_in, retransmit_strobe_in, flag_sync_select_in} = 4'hF;
        {output_enable_n_in, reg_wr_in, reg_rd_in, reg_addr_in} = 5'h00;
        {ce_in, fl, cwi, cri} = 4'h8;
        reg_wdata_in = 32'h0;
        err_total = 0;
        checks = 0;
        last = 0;
        seed = 32'd79034;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        fifo_clear();
        wr(18'h2, 1);
        wr(18'h3, 1);
        rd(1);
        rd(1);
        repeat (DEPTH + 1) wr(rnd(), 0);
        reg_io(2'h1, 32'h1, 1);
        reg_io(2'h1, 32'h0, 0);
        cmp(reg_rdata_out, 32'h1);
        reg_io(2'h1, 32'h0, 1);
        reg_io(2'h2, 32'h3FFFF, 1);
        reg_io(2'h2, 32'h0, 0);
        cmp(reg_rdata_out, oae);
        reg_io(2'h0, 32'h0, 0);
        cmp(reg_rdata_out, (DEPTH << 16) | 32'h76 | e);
        repeat (DEPTH + 2) rd(0);
        repeat (2) wr(rnd(), 0);
        output_enable_n_in <= 1'b1;
        flag_sync_select_in <= 1'b0;
        ce_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        cmp(read_bus_oe_out, 1'b1);
        ce_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        cmp(read_bus_oe_out, 1'b0);
        output_enable_n_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        cmp(read_bus_oe_out, 1'b1);
        fifo_clear();
        repeat (5) wr(rnd(), 0);
        repeat (3) rd(0);
        retransmit_strobe_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        retransmit_strobe_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        q = hist;
        repeat (6) rd(0);
        fl <= 1'b1;
        reg_io(2'h1, 32'h1, 1);
        casc = 1'b1;
        fifo_clear();
        reg_io(2'h0, 32'h0, 0);
        cmp(reg_rdata_out, 32'h09);
        @(posedge clk_in);
        {cwi, cri} <= 2'b11;
        repeat (5) @(posedge clk_in);
        {cwi, cri} <= 2'b00;
        reg_io(2'h0, 32'h0, 0);
        cmp(reg_rdata_out, 32'h69);
        repeat (DEPTH) wr(rnd(), 0);
        cmp(wxo_n, 1);
        repeat (DEPTH + 1) rd(0);
        cmp(rxo_n, 1);
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        finish_test();
    end
endmodule // deep_sync_fifo_tb
bind deep_sync_fifo deep_sync_fifo_checker #(.DW(DW), .AW(AW)) chk (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .write_clock_in(write_clock_in),
    .read_clock_in(read_clock_in), .fifo_reset_n_in(fifo_reset_n_in),
    .flag_sync_select_in(flag_sync_select_in), .output_enable_n_in(output_enable_n_in),
    .reg_rd_in(reg_rd_in), .read_bus_out(read_bus_out), .read_bus_oe_out(read_bus_oe_out),
    .empty_flag_n_out(empty_flag_n_out), .full_flag_n_out(full_flag_n_out),
    .almost_empty_flag_n_out(almost_empty_flag_n_out),
    .almost_full_flag_n_out(almost_full_flag_n_out), .reg_rdata_out(reg_rdata_out));
`default_nettype wire
